// File: hlink_host.sv
// Host controller for a monitor chain: builds command frames, sends them on
// the serial link and collects response frames. Software talks over APB.
// Assumes RX idles high with a pull-up and TX is only driven by this block.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
module hlink_host #(
    parameter int TIMEOUT = hlink_pkg::TIMEOUT_CYCLES,
    parameter int BREAK_LEN = hlink_pkg::BREAK_CYCLES,
    parameter int GUARD_LEN = hlink_pkg::GUARD_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic UART_TX,
    input wire logic UART_RX
);
    localparam int TW = $clog2(TIMEOUT + BREAK_LEN + GUARD_LEN + 2);
    localparam logic [7:0] BIT_LAST = 8'(hlink_pkg::BIT_CYCLES - 1);
    localparam logic [7:0] BIT_HALF = 8'(hlink_pkg::BIT_CYCLES / 2);

    hlink_pkg::state_t state; // Sequence state
    hlink_pkg::cmd_t cmd; // Command word
    logic [63:0] data_q; // Write payload, byte 0 lowest
    logic [7:0] resp_exp; // Responses expected for a read
    logic [7:0] resp_got; // Responses taken so far
    logic [5:0] last_addr; // Responder of the latest good frame
    logic [5:0] flags; // Sticky status flags
    logic [TW-1:0] tmr; // Break, guard and timeout timer
    logic [3:0] idx; // Transmit byte index
    logic [15:0] crc_tx; // Running transmit CRC
    logic [7:0] rx_buf [128]; // Data of latest response
    // Serial transmitter
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic [7:0] tx_cnt;
    // Serial receiver
    logic rx_m;
    logic rx_s;
    logic rx_on;
    logic [3:0] rx_bit;
    logic [7:0] rx_cnt;
    logic [8:0] rx_sh;
    logic rx_valid;
    logic [7:0] rx_byte;
    // Response parser
    logic [7:0] ridx;
    logic [6:0] rlen;
    logic [15:0] crc_rx;
    logic [31:0] rd_word;
    logic cmd_go_q; // A frame follows the break
    logic [5:0] addr_q; // Responder address of the frame in flight

    // Bus decode
    wire wr = PSEL && PENABLE && PWRITE;
    wire hit_ctrl = PADDR == hlink_pkg::OFS_CTRL;
    wire hit_cmd = PADDR == hlink_pkg::OFS_CMD;
    wire hit_d0 = PADDR == hlink_pkg::OFS_DATA0;
    wire hit_d1 = PADDR == hlink_pkg::OFS_DATA1;
    wire hit_resp = PADDR == hlink_pkg::OFS_RESP;
    wire hit_stat = PADDR == hlink_pkg::OFS_STAT;
    wire hit_buf = PADDR[11:9] == hlink_pkg::OFS_BUF[11:9] && PADDR[8:7] == 2'b00;
    wire mapped = hit_ctrl | hit_cmd | hit_d0 | hit_d1 | hit_resp | hit_stat | hit_buf;
    wire go = wr && hit_ctrl && PWDATA[hlink_pkg::CTRL_GO] && state == hlink_pkg::ST_IDLE;
    wire brk_only = wr && hit_ctrl && PWDATA[hlink_pkg::CTRL_BREAK_ONLY] && state == hlink_pkg::ST_IDLE;
    wire go_rsvd = go && cmd.req == hlink_pkg::REQ_RSVD;
    wire [6:0] buf_base = {PADDR[6:2], 2'b00};

    // Frame layout
    wire has_addr = cmd.req == hlink_pkg::REQ_SREAD || cmd.req == hlink_pkg::REQ_SWRITE;
    wire is_read = cmd.req == hlink_pkg::REQ_SREAD || cmd.req == hlink_pkg::REQ_KREAD
        || cmd.req == hlink_pkg::REQ_BREAD;
    wire [3:0] n_data = is_read ? 4'h1 : {1'b0, cmd.size} + 4'h1;
    wire [3:0] hdr = has_addr ? 4'h4 : 4'h3;
    wire [3:0] total = hdr + n_data + 4'h2;
    wire [3:0] k = idx - {3'b000, has_addr};
    wire [2:0] dsel = 3'(idx - hdr);
    wire [7:0] init_byte = {1'b1, cmd.req, 1'b0, is_read ? 3'b000 : cmd.size};
    wire [7:0] addr_byte = {2'b00, cmd.dev};
    wire [7:0] data_byte = is_read ? data_q[7:0] : data_q[{dsel, 3'b000} +: 8];
    wire tx_busy = tx_bits != 4'h0;
    wire tx_load = state == hlink_pkg::ST_SEND && !tx_busy && idx < total;
    logic [7:0] tx_byte;

    // Byte order of a command frame
    always_comb begin
        if (idx == 4'h0) begin // Initialization byte first
            tx_byte = init_byte;
        end else if (has_addr && idx == 4'h1) begin // Address only for single commands
            tx_byte = addr_byte;
        end else if (k == 4'h1) begin // Register address high byte
            tx_byte = cmd.reg_addr[15:8];
        end else if (k == 4'h2) begin // Register address low byte
            tx_byte = cmd.reg_addr[7:0];
        end else if (idx < hdr + n_data) begin // Payload
            tx_byte = data_byte;
        end else if (idx == hdr + n_data) begin // CRC low byte first
            tx_byte = crc_tx[7:0];
        end else begin // CRC high byte
            tx_byte = crc_tx[15:8];
        end
    end

    // Parser view of the incoming byte
    wire [15:0] crc_rx_next = hlink_pkg::crc_byte(ridx == 8'h00 ? hlink_pkg::CRC_INIT : crc_rx, rx_byte);
    wire in_wait = state == hlink_pkg::ST_WAIT;
    wire rx_init = in_wait && rx_valid && ridx == 8'h00;
    wire rx_bad_type = rx_init && rx_byte[7];
    wire rx_end = in_wait && rx_valid && ridx != 8'h00 && ridx == {1'b0, rlen} + 8'h06;
    wire rx_ok = rx_end && crc_rx_next == 16'h0000;
    wire last_resp = resp_got + 8'h01 >= resp_exp;
    wire tmr_done = tmr == '0;

    // Sticky flag set terms; a set in the clearing cycle wins
    logic [5:0] fl_set;
    always_comb begin
        fl_set = 6'h00;
        fl_set[hlink_pkg::FL_DONE] = (state == hlink_pkg::ST_SEND && idx == total && !tx_busy
            && (!is_read || resp_exp == 8'h00)) || (rx_end && last_resp);
        fl_set[hlink_pkg::FL_TMO] = in_wait && tmr_done && !rx_valid;
        fl_set[hlink_pkg::FL_CRC] = rx_end && !rx_ok;
        fl_set[hlink_pkg::FL_PROTO] = rx_bad_type;
        fl_set[hlink_pkg::FL_RSVD] = go_rsvd;
        fl_set[hlink_pkg::FL_UNSOL] = rx_valid && !in_wait;
    end

    // Register writes from software
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cmd <= '0;
            data_q <= 64'h0;
            resp_exp <= 8'h01;
            flags <= 6'h00;
        end else begin
            if (wr && hit_cmd && state == hlink_pkg::ST_IDLE) cmd <= hlink_pkg::cmd_t'(PWDATA);
            if (wr && hit_d0 && state == hlink_pkg::ST_IDLE) data_q[31:0] <= PWDATA;
            if (wr && hit_d1 && state == hlink_pkg::ST_IDLE) data_q[63:32] <= PWDATA;
            if (wr && hit_resp && state == hlink_pkg::ST_IDLE) resp_exp <= PWDATA[7:0];
            flags <= (flags & ~((wr && hit_stat) ? PWDATA[6:1] : 6'h00)) | fl_set;
        end
    end

    // Read data mux
    always_comb begin
        rd_word = 32'h0;
        if (hit_ctrl) rd_word = 32'h0;
        if (hit_cmd) rd_word = cmd;
        if (hit_d0) rd_word = data_q[31:0];
        if (hit_d1) rd_word = data_q[63:32];
        if (hit_resp) rd_word = {24'h0, resp_exp};
        if (hit_stat) rd_word = {10'h0, last_addr, resp_got, 1'b0, flags, state != hlink_pkg::ST_IDLE};
        if (hit_buf) rd_word = {rx_buf[buf_base + 7'h3], rx_buf[buf_base + 7'h2],
            rx_buf[buf_base + 7'h1], rx_buf[buf_base]};
    end

    // Read data is captured in the setup cycle and held through the access
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) PRDATA <= 32'h0;
        else if (PSEL && !PENABLE) PRDATA <= rd_word;
    end
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // Controller sequence
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= hlink_pkg::ST_IDLE;
            tmr <= '0;
            idx <= 4'h0;
            crc_tx <= hlink_pkg::CRC_INIT;
        end else begin
            case (state)
                hlink_pkg::ST_IDLE: begin // Break only from idle, reached once the answers are in, the wait times out or a bad type arrives
                    idx <= 4'h0;
                    crc_tx <= hlink_pkg::CRC_INIT;
                    if (brk_only || (go && !go_rsvd && PWDATA[hlink_pkg::CTRL_BREAK])) begin
                        state <= hlink_pkg::ST_BREAK;
                        tmr <= TW'(BREAK_LEN - 1);
                    end else if (go && !go_rsvd) begin // Reserved code never sent
                        state <= hlink_pkg::ST_SEND;
                    end
                end
                hlink_pkg::ST_BREAK: begin // Line held low
                    tmr <= tmr - 1'b1;
                    if (tmr_done) begin
                        state <= hlink_pkg::ST_GUARD;
                        tmr <= TW'(GUARD_LEN - 1);
                    end
                end
                hlink_pkg::ST_GUARD: begin // Idle gap, then the frame, or back to idle after a break-only request
                    tmr <= tmr - 1'b1;
                    if (tmr_done) state <= cmd_go_q ? hlink_pkg::ST_SEND : hlink_pkg::ST_IDLE;
                end
                hlink_pkg::ST_SEND: begin
                    if (tx_load) begin
                        idx <= idx + 4'h1;
                        if (idx < hdr + n_data) crc_tx <= hlink_pkg::crc_byte(crc_tx, tx_byte);
                    end else if (idx == total && !tx_busy) begin
                        state <= (is_read && resp_exp != 8'h00) ? hlink_pkg::ST_WAIT : hlink_pkg::ST_IDLE;
                        tmr <= TW'(TIMEOUT - 1);
                    end
                end
                hlink_pkg::ST_WAIT: begin // No new frame until answers, timeout or a bad response type
                    tmr <= rx_valid ? TW'(TIMEOUT - 1) : tmr - 1'b1;
                    if (rx_bad_type || (rx_end && last_resp) || (tmr_done && !rx_valid)) begin
                        state <= hlink_pkg::ST_IDLE;
                    end
                end
                default: state <= hlink_pkg::ST_IDLE;
            endcase
        end
    end

    // Remembers that a frame follows the break
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) cmd_go_q <= 1'b0;
        else if (state == hlink_pkg::ST_IDLE) cmd_go_q <= go && !go_rsvd;
    end

    // Transmitter: 8-N-1, LSB first, low during a break
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_sh <= 10'h3ff;
            tx_bits <= 4'h0;
            tx_cnt <= 8'h00;
            UART_TX <= 1'b1;
        end else begin
            UART_TX <= (state == hlink_pkg::ST_BREAK) ? 1'b0 : (tx_busy ? tx_sh[0] : 1'b1);
            if (tx_load) begin
                tx_sh <= {1'b1, tx_byte, 1'b0};
                tx_bits <= 4'ha;
                tx_cnt <= BIT_LAST;
            end else if (tx_busy) begin
                tx_cnt <= (tx_cnt == 8'h00) ? BIT_LAST : tx_cnt - 8'h01;
                if (tx_cnt == 8'h00) begin
                    tx_sh <= {1'b1, tx_sh[9:1]};
                    tx_bits <= tx_bits - 4'h1;
                end
            end
        end
    end

    // Two-stage synchroniser on the receive pin
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_m <= 1'b1;
            rx_s <= 1'b1;
        end else begin
            rx_m <= UART_RX;
            rx_s <= rx_m;
        end
    end

    // Receiver: mid-bit sampling from the start edge
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_on <= 1'b0;
            rx_bit <= 4'h0;
            rx_cnt <= 8'h00;
            rx_sh <= 9'h000;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (!rx_on) begin
                if (!rx_s) begin // Start edge
                    rx_on <= 1'b1;
                    rx_bit <= 4'h0;
                    rx_cnt <= BIT_HALF;
                end
            end else if (rx_cnt != 8'h00) begin
                rx_cnt <= rx_cnt - 8'h01;
            end else begin
                rx_cnt <= BIT_LAST;
                rx_bit <= rx_bit + 4'h1;
                rx_sh <= {rx_s, rx_sh[8:1]};
                if (rx_bit == 4'h0 && rx_s) begin // False start
                    rx_on <= 1'b0;
                end else if (rx_bit == 4'h9) begin // Stop bit sampled
                    rx_on <= 1'b0;
                    rx_valid <= 1'b1;
                    rx_byte <= rx_sh[8:1];
                end
            end
        end
    end

    // Response parser: init, responder address, register, data, CRC
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ridx <= 8'h00;
            rlen <= 7'h00;
            crc_rx <= hlink_pkg::CRC_INIT;
            resp_got <= 8'h00;
            last_addr <= 6'h00;
        end else if (!in_wait) begin
            ridx <= 8'h00;
            if (go) resp_got <= 8'h00;
        end else if (rx_valid) begin
            crc_rx <= crc_rx_next;
            ridx <= rx_end ? 8'h00 : ridx + 8'h01;
            if (ridx == 8'h00) rlen <= rx_byte[6:0];
            if (rx_end) resp_got <= resp_got + 8'h01;
            if (rx_ok) last_addr <= addr_q;
        end
    end

    // Responder address and data capture
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) addr_q <= 6'h00;
        else if (in_wait && rx_valid && ridx == 8'h01) addr_q <= rx_byte[5:0];
    end
    always_ff @(posedge CLK) begin
        if (in_wait && rx_valid && ridx >= 8'h04 && ridx < {1'b0, rlen} + 8'h05) rx_buf[7'(ridx - 8'h04)] <= rx_byte;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_break_line_low: assert property (state == hlink_pkg::ST_BREAK && $past(state) == hlink_pkg::ST_BREAK |-> !UART_TX)
        else $error("TX not low during break");
    a_init_cmd_type: assert property (tx_load && idx == 4'h0 |-> tx_byte[7])
        else $error("Command init bit 7 not set");
    a_init_req_code: assert property (tx_load && idx == 4'h0 |-> tx_byte[6:4] == cmd.req)
        else $error("Request code mismatch");
    a_init_size: assert property (tx_load && idx == 4'h0 && !is_read |-> tx_byte[2:0] == cmd.size)
        else $error("Size field mismatch");
    a_addr_top_zero: assert property (tx_load && has_addr && idx == 4'h1 |-> tx_byte[7:6] == 2'b00)
        else $error("Address byte top bits set");
    a_no_addr_group: assert property (tx_load && !has_addr && idx == 4'h1 |-> tx_byte == cmd.reg_addr[15:8])
        else $error("Address byte in group frame");
    a_read_count: assert property (tx_load && is_read && idx == hdr |-> tx_byte == data_q[7:0])
        else $error("Read count byte wrong");
    a_rsvd_refused: assert property (go_rsvd |=> state == hlink_pkg::ST_IDLE && flags[hlink_pkg::FL_RSVD])
        else $error("Reserved request not refused");
    a_wait_no_send: assert property (state == hlink_pkg::ST_WAIT |=> state inside {hlink_pkg::ST_WAIT, hlink_pkg::ST_IDLE})
        else $error("New frame before answers");
    a_crc_flagged: assert property (rx_end && crc_rx_next != 16'h0000 |=> flags[hlink_pkg::FL_CRC])
        else $error("Bad CRC not flagged");
endmodule : hlink_host

// File: hlink_pkg.sv
// Constants, field layouts and types for the host-side chain link controller.
// Assumes a single 100 MHz clock and a 1 Mbps 8-N-1 half-duplex serial link.
// Notes on behaviour
// - Host breaks only after all responses arrived; this block also breaks after a timeout or bad response type.
// - Multidrop host sends break before every frame; this block breaks only when CTRL_BREAK or CTRL_BREAK_ONLY is set.
// - Host waits responses or timeout before next.
// - Frame: init, address, register, data, CRC.
// - Init bit 7: command 1, response 0.
// - Request type bits 6:4 encode command.
// - Init bits 2:0 give length minus one.
// - Address byte only in single-device commands.
// - Address byte: top bits zero, six-bit address.
// - Register address two bytes, high first.
// - Read data byte is count minus one.
// - CRC-16, LSB first, init ones, poly 0xC002.
package hlink_pkg;
    // Timing
    localparam int CLK_NS = 10;
    localparam int BIT_NS = 1000;
    localparam int BIT_CYCLES = BIT_NS / CLK_NS;
    localparam int BREAK_BITS = 12;
    localparam int BREAK_CYCLES = BREAK_BITS * BIT_CYCLES;
    localparam int GUARD_BITS = 4;
    localparam int GUARD_CYCLES = GUARD_BITS * BIT_CYCLES;
    localparam int TIMEOUT_US = 1000;
    localparam int TIMEOUT_CYCLES = (TIMEOUT_US * 1000) / CLK_NS;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_DATA0 = 12'h008;
    localparam logic [11:0] OFS_DATA1 = 12'h00c;
    localparam logic [11:0] OFS_RESP = 12'h010;
    localparam logic [11:0] OFS_STAT = 12'h014;
    localparam logic [11:0] OFS_BUF = 12'h200;
    // Control bits
    localparam int CTRL_GO = 0;
    localparam int CTRL_BREAK = 1;
    localparam int CTRL_BREAK_ONLY = 2;
    // Sticky flag positions inside the flag vector
    localparam int FL_DONE = 0;
    localparam int FL_TMO = 1;
    localparam int FL_CRC = 2;
    localparam int FL_PROTO = 3;
    localparam int FL_RSVD = 4;
    localparam int FL_UNSOL = 5;
    // Request type codes
    localparam logic [2:0] REQ_SREAD = 3'h0;
    localparam logic [2:0] REQ_SWRITE = 3'h1;
    localparam logic [2:0] REQ_KREAD = 3'h2;
    localparam logic [2:0] REQ_BREAD = 3'h4;
    localparam logic [2:0] REQ_RSVD = 3'h7;
    // Frame check
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
    // Command word as software writes it
    typedef struct packed {
        logic [15:0] reg_addr;
        logic [1:0] pad;
        logic [5:0] dev;
        logic rsvd_hi;
        logic [2:0] size;
        logic rsvd_lo;
        logic [2:0] req;
    } cmd_t;
    // Controller sequence
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_BREAK = 3'h1,
        ST_GUARD = 3'h3,
        ST_SEND = 3'h2,
        ST_WAIT = 3'h6
    } state_t;
    // One byte through the reflected CRC, LSB first
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
        end
        return c;
    endfunction : crc_byte
endpackage : hlink_pkg

// File: hlink_dev_model.sv
// Behavioural base device of a monitor chain, seen from the host serial pair.
// Assumes 100 clocks per bit, LSB first, and the bench clock as its timebase.
module hlink_dev_model #(
    parameter logic [5:0] DEV_ADDR = 6'h02,
    parameter logic STACK_MEMBER = 1'b0,
    parameter logic DIR_SEL = 1'b0,
    parameter logic [5:0] ALT_ADDR = 6'h03
) (
    input wire logic clk,
    input wire logic rx_line,
    input wire logic bad_crc,
    output logic tx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] MY_ADDR = DIR_SEL ? ALT_ADDR : DEV_ADDR;
    int low_run = 0, n_cut = 0, phase = 0; // Break timer, cut answers, 1 pending 2 sending
    logic pending_response_wait_flag = 1'b0, break_during_transmit_flag = 1'b0; // Debug marks
    // A break while an answer is due drops it and marks why
    always @(posedge clk) begin
        low_run <= rx_line ? 0 : low_run + 1;
        if (low_run == 1000 && phase != 0) begin
            n_cut <= n_cut + 1;
            if (phase == 2) break_during_transmit_flag <= 1'b1;
            else pending_response_wait_flag <= 1'b1;
        end
    end
    logic [7:0] regs [0:255]; // Valid register space
    logic [7:0] frm [0:15]; // Last command frame
    logic [7:0] rsp [0:133]; // Response being sent
    logic brk; // Low stop bit seen
    logic [15:0] c; // Running check value
    int n_frames, n_breaks, n_crc_err, n_rsvd, last_len, len;
    // Reflected check step, one bit at a time
    function automatic logic [15:0] crc_step(input logic [15:0] v, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            v = (v[0] ^ b[i]) ? ((v >> 1) ^ 16'ha001) : (v >> 1);
        end
        return v;
    endfunction : crc_step
    // One byte in, sampled mid-bit
    task automatic get_byte(output logic [7:0] b);
        while (rx_line !== 1'b0) @(posedge clk);
        repeat (50) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (100) @(posedge clk);
            b[i] = rx_line;
        end
        repeat (100) @(posedge clk);
        brk = (rx_line === 1'b0);
        while (rx_line !== 1'b1) @(posedge clk);
    endtask : get_byte
    // One byte out with start and stop
    task automatic put_byte(input logic [7:0] b);
        for (int i = -1; i < 9; i++) begin
            tx_line <= (i < 0) ? 1'b0 : ((i > 7) ? 1'b1 : b[i]);
            repeat (100) @(posedge clk);
        end
    endtask : put_byte
    // Act on a frame whose check passed
    task automatic exec(input int n);
        int k;
        int cnt;
        int n0;
        logic [2:0] req;
        logic hit;
        logic [15:0] ra;
        req = frm[0][6:4];
        k = (req < 3'h2) ? 2 : 1;
        ra = {frm[k], frm[k + 1]};
        hit = (req < 3'h2) ? (frm[1] === {2'b00, MY_ADDR}) : (req[2] || STACK_MEMBER);
        last_len = n;
        n_frames++;
        if (req == 3'h7) begin
            n_rsvd++;
        end else if (hit && (req inside {3'h1, 3'h3, 3'h5, 3'h6})) begin
            for (int i = 0; i < n - k - 4; i++) begin
                if (32'(ra) + i < 256) regs[8'(32'(ra) + i)] = frm[k + 2 + i];
            end
        end else if (hit) begin
            cnt = int'(frm[k + 2][6:0]) + 1;
            rsp[0] = {1'b0, frm[k + 2][6:0]};
            rsp[1] = {2'b00, MY_ADDR};
            rsp[2] = frm[k];
            rsp[3] = frm[k + 1];
            for (int i = 0; i < cnt; i++) begin
                rsp[4 + i] = (32'(ra) + i < 256) ? regs[8'(32'(ra) + i)] : 8'h00;
            end
            c = 16'hffff;
            for (int i = 0; i < cnt + 4; i++) c = crc_step(c, rsp[i]);
            rsp[cnt + 4] = c[7:0] ^ {7'h00, bad_crc};
            rsp[cnt + 5] = c[15:8];
            phase = 1;
            n0 = n_cut;
            repeat (200) @(posedge clk);
            phase = 2;
            for (int i = 0; i < cnt + 6 && n_cut == n0; i++) put_byte(rsp[i]);
            phase = 0;
        end
    endtask : exec
    // Receive, check and serve frames forever
    initial begin
        tx_line = 1'b1;
        brk = 1'b0;
        {n_frames, n_breaks, n_crc_err, n_rsvd, last_len} = '0;
        for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
        forever begin
            get_byte(frm[0]);
            len = int'(frm[0][2:0]) + ((frm[0][6:4] < 3'h2) ? 7 : 6);
            for (int n = 1; n < len && !brk; n++) get_byte(frm[n]);
            c = 16'hffff;
            for (int n = 0; n < len; n++) c = crc_step(c, frm[n]);
            if (brk) n_breaks++;
            else if (c !== 16'h0000) n_crc_err++;
            else exec(len);
        end
    end
endmodule : hlink_dev_model

// File: hlink_host_tb.sv
// Self-checking bench for the host link controller: APB tasks give orders,
// a behavioural device answers on the serial pair.
module hlink_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CEIL = 95000; // Cycle budget of the run
    logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, UART_TX, UART_RX, bad_crc, err;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    int n_errors, n_compared, cycles, nb;
    hlink_host #(.TIMEOUT(3000)) i_hlink_host (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .UART_TX(UART_TX), .UART_RX(UART_RX));
    hlink_dev_model i_hlink_dev_model (.clk(CLK), .rx_line(UART_TX), .bad_crc(bad_crc), .tx_line(UART_RX));
    // Free-running clock
    always #5 CLK = ~CLK;
    // Hang guard
    always @(posedge CLK) begin
        cycles++;
        if (cycles == CEIL) begin
            n_errors++;
            print_verdict();
        end
    end
    // One APB transfer, held until PREADY
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    // Compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Load a command, start it and wait until idle
    task automatic run(input string name, input logic [2:0] req, input logic [2:0] size, input logic [5:0] dev,
        input logic [15:0] ra, input logic [31:0] d0, input logic [31:0] nresp, input logic [31:0] ctrl);
        hlink_pkg::cmd_t c;
        c = '{reg_addr: ra, pad: 2'b00, dev: dev, rsvd_hi: 1'b0, size: size, rsvd_lo: 1'b0, req: req};
        apb(1'b1, hlink_pkg::OFS_STAT, 32'h0000007e);
        apb(1'b1, hlink_pkg::OFS_CMD, c);
        apb(1'b1, hlink_pkg::OFS_DATA0, d0);
        apb(1'b1, hlink_pkg::OFS_RESP, nresp);
        apb(1'b1, hlink_pkg::OFS_CTRL, ctrl);
        repeat (2) @(posedge CLK);
        rd = 32'h1;
        while (rd[0] !== 1'b0) apb(1'b0, hlink_pkg::OFS_STAT, 32'h0);
        $display("test %s done", name);
    endtask : run
    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // Main sequence
    initial begin
        {CLK, PSEL, PENABLE, PWRITE, bad_crc} = '0;
        {PADDR, PWDATA} = '0;
        RST = 1'b1;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        apb(1'b0, hlink_pkg::OFS_STAT, 32'h0);
        chk("status after reset", 32'h0, rd);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        run("single write", 3'h1, 3'h3, 6'h02, 16'h0010, 32'h11223344, 32'h0, 32'h1);
        chk("write init byte", 32'h93, {24'h0, i_hlink_dev_model.frm[0]});
        chk("write address byte", 32'h02, {24'h0, i_hlink_dev_model.frm[1]});
        chk("write register", 32'h0010, {16'h0, i_hlink_dev_model.frm[2], i_hlink_dev_model.frm[3]});
        chk("write first data", 32'h44, {24'h0, i_hlink_dev_model.frm[4]});
        chk("command check errors", 32'h0, 32'(i_hlink_dev_model.n_crc_err));
        chk("stored bytes", 32'h11223344, {i_hlink_dev_model.regs[19], i_hlink_dev_model.regs[18],
            i_hlink_dev_model.regs[17], i_hlink_dev_model.regs[16]});
        run("single read", 3'h0, 3'h0, 6'h02, 16'h0010, 32'h3, 32'h1, 32'h1);
        apb(1'b0, hlink_pkg::OFS_STAT, 32'h0);
        chk("read status", 32'h00020102, rd);
        apb(1'b0, hlink_pkg::OFS_BUF, 32'h0);
        chk("read data", 32'h11223344, rd);
        run("broadcast read", 3'h4, 3'h0, 6'h00, 16'h00fe, 32'h3, 32'h1, 32'h1);
        chk("broadcast frame length", 32'd6, 32'(i_hlink_dev_model.last_len));
        chk("broadcast init byte", 32'hc0, {24'h0, i_hlink_dev_model.frm[0]});
        apb(1'b0, hlink_pkg::OFS_BUF, 32'h0);
        chk("invalid registers read zero", 32'h0000a5a4, rd);
        bad_crc <= 1'b1;
        run("bad response check", 3'h0, 3'h0, 6'h02, 16'h0000, 32'h0, 32'h1, 32'h1);
        bad_crc <= 1'b0;
        apb(1'b0, hlink_pkg::OFS_STAT, 32'h0);
        chk("check error flag", 32'h1, {31'h0, rd[3]});
        run("no answer", 3'h0, 3'h0, 6'h05, 16'h0000, 32'h0, 32'h1, 32'h1);
        apb(1'b0, hlink_pkg::OFS_STAT, 32'h0);
        chk("timeout flag and count", 32'h1, {23'h0, rd[15:8], rd[2]});
        nb = i_hlink_dev_model.n_frames;
        run("reserved type", 3'h7, 3'h0, 6'h02, 16'h0000, 32'h0, 32'h0, 32'h1);
        apb(1'b0, hlink_pkg::OFS_STAT, 32'h0);
        chk("reserved flag", 32'h1, {31'h0, rd[5]});
        chk("reserved not sent", 32'(nb), 32'(i_hlink_dev_model.n_frames));
        nb = i_hlink_dev_model.n_breaks;
        run("break then write", 3'h1, 3'h0, 6'h02, 16'h0020, 32'h77, 32'h0, 32'h3);
        chk("break seen", 32'(nb + 1), 32'(i_hlink_dev_model.n_breaks));
        chk("write after break", 32'h77, {24'h0, i_hlink_dev_model.regs[32]});
        run("broadcast write", 3'h5, 3'h1, 6'h00, 16'h0030, 32'h0000bbaa, 32'h0, 32'h1);
        chk("broadcast write init", 32'hd1, {24'h0, i_hlink_dev_model.frm[0]});
        chk("broadcast write length", 32'd7, 32'(i_hlink_dev_model.last_len));
        chk("broadcast stored", 32'hbbaa, {16'h0, i_hlink_dev_model.regs[49], i_hlink_dev_model.regs[48]});
        apb(1'b1, hlink_pkg::OFS_STAT, 32'h0000007e);
        apb(1'b0, hlink_pkg::OFS_STAT, 32'h0);
        chk("flags cleared", 32'h0, {25'h0, rd[6:0]});
        print_verdict();
    end
endmodule : hlink_host_tb
